/* tcs_cfg.svh */
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// Register addresses on the special function register port
`define TCS_CTRL_ADDR        8'h88
`define TCS_CKSEL_A_ADDR     8'h8e
`define TCS_CKSEL_B_ADDR     8'ha6

// Reset values
`define TCS_CTRL_RESET       8'h00
`define TCS_CKSEL_A_RESET    8'h00
`define TCS_CKSEL_B_RESET    4'h0

// Control register field positions
`define TCS_T1_OVF_BIT       7
`define TCS_T1_RUN_BIT       6
`define TCS_T0_OVF_BIT       5
`define TCS_T0_RUN_BIT       4
`define TCS_EIRQ1_FLAG_BIT   3
`define TCS_EIRQ1_TYPE_BIT   2
`define TCS_EIRQ0_FLAG_BIT   1
`define TCS_EIRQ0_TYPE_BIT   0

// Clock select register A field positions
`define TCS_T3_UPPER_BIT     7
`define TCS_T3_LOWER_BIT     6
`define TCS_T2_UPPER_BIT     5
`define TCS_T2_LOWER_BIT     4
`define TCS_T1_SEL_BIT       3
`define TCS_T0_SEL_BIT       2
`define TCS_DIV_SEL_HI       1
`define TCS_DIV_SEL_LO       0

// Clock select register B field positions
`define TCS_T5_UPPER_BIT     3
`define TCS_T5_LOWER_BIT     2
`define TCS_T4_UPPER_BIT     1
`define TCS_T4_LOWER_BIT     0
`define TCS_CKSEL_B_WIDTH    4

// Prescaler division counts in system clocks
`define TCS_DIV12_COUNT      6'd12
`define TCS_DIV4_COUNT       6'd4
`define TCS_DIV48_COUNT      6'd48

`endif

/* tcs_ext_irq.sv */
`timescale 1ns/100ps

module tcs_ext_irq (
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    input  wire logic clk_en_i,
    input  wire logic pin_i,
    input  wire logic polarity_i,
    input  wire logic edge_mode_i,
    input  wire logic wr_en_i,
    input  wire logic wr_val_i,
    input  wire logic vector_i,
    output logic      flag_o,
    output logic      active_o
);
    import tcs_pkg::*;

    tcs_eirq_state_t q;
    tcs_eirq_state_t d;
    logic            level_now;
    logic            hit;

    always_comb begin
        // Polarity 1 means the pin is active high
        level_now = polarity_i ? pin_i : ~pin_i; // R13
        hit       = edge_mode_i ? (level_now & ~q.active) : level_now; // R13
        d         = q;
        d.active  = level_now;
        if (wr_en_i) begin
            d.flag = wr_val_i;
        end
        if (vector_i && edge_mode_i) begin // R10
            d.flag = 1'b0;
        end
        // Detection beats a same-cycle clear
        if (hit) begin // R10
            d.flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign flag_o   = q.flag;
    assign active_o = q.active;

endmodule : tcs_ext_irq

/* tcs_pkg.sv */
package tcs_pkg;

    typedef enum logic [1:0] {
        TCS_DIV_12   = 2'h0,
        TCS_DIV_4    = 2'h1,
        TCS_DIV_48   = 2'h2,
        TCS_DIV_RSVD = 2'h3
    } tcs_div_sel_t;

    typedef struct packed {
        logic [5:0] count;
        logic       tick;
    } tcs_presc_state_t;

    typedef struct packed {
        logic active;
        logic flag;
    } tcs_eirq_state_t;

    typedef struct packed {
        logic       timer1_overflow_flag;
        logic       timer1_run_bit;
        logic       timer0_overflow_flag;
        logic       timer0_run_bit;
        logic       ext_irq1_type_sel;
        logic       ext_irq0_type_sel;
        logic [7:0] cksel_a;
        logic [3:0] cksel_b;
        logic       t0_tick;
        logic       t1_tick;
        logic [3:0] lower_tick;
        logic [3:0] upper_tick;
        logic       t0_count_en;
        logic       t1_count_en;
        logic [7:0] rdata;
    } tcs_top_state_t;

endpackage : tcs_pkg

/* tcs_prescaler.sv */
`timescale 1ns/100ps
`include "tcs_cfg.svh"

module tcs_prescaler #(
    parameter int COUNT_W = 6
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  clk_en_i,
    input  wire tcs_pkg::tcs_div_sel_t div_sel_i,
    output logic                       tick_o
);
    import tcs_pkg::*;

    tcs_presc_state_t q;
    tcs_presc_state_t d;
    logic [5:0]       limit;

    always_comb begin
        unique case (div_sel_i)
            TCS_DIV_4:  limit = `TCS_DIV4_COUNT;
            TCS_DIV_48: limit = `TCS_DIV48_COUNT;
            default:    limit = `TCS_DIV12_COUNT;
        endcase
        d = q;
        // Compare with >= so a shorter ratio chosen mid-count wraps at once
        if (q.count >= limit - 6'd1) begin // R09
            d.count = 6'h00;
            d.tick  = 1'b1;
        end else begin
            d.count = q.count + 6'd1;
            d.tick  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule : tcs_prescaler

/* tcs_top.sv */
`timescale 1ns/100ps
`include "tcs_cfg.svh"

// Behaviour
// R01: Timer2 upper byte clock select, split only
// R02: Timer2 lower/whole timer clock select
// R03: Timer3 upper and lower clock selects
// R04: Timer4 clock selects in register B
// R05: Timer5 clock selects in register B
// R06: Timer1 uses system clock or prescaler
// R07: Timer0 uses system clock or prescaler
// R08: Counter mode ignores timer0/1 clock selects
// R09: Prescaler divides by 12, 4, 48
// R10: External flags set, cleared, auto-cleared edge
// R11: Timer0 runs when run and gate permit
// R12: Overflow flags set, cleared, auto-cleared on vector
// R13: Type bit picks level or edge trigger
module tcs_top (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       clk_en_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       timer0_counter_mode_i,
    input  wire logic       timer1_counter_mode_i,
    input  wire logic       timer0_pin_tick_i,
    input  wire logic       timer1_pin_tick_i,
    input  wire logic       timer0_gating_bit_i,
    input  wire logic       timer1_gating_bit_i,
    input  wire logic       ext_irq0_input_i,
    input  wire logic       ext_irq1_input_i,
    input  wire logic       ext_irq0_polarity_i,
    input  wire logic       ext_irq1_polarity_i,
    input  wire logic       timer0_overflow_i,
    input  wire logic       timer1_overflow_i,
    input  wire logic       timer0_vector_i,
    input  wire logic       timer1_vector_i,
    input  wire logic       ext_irq0_vector_i,
    input  wire logic       ext_irq1_vector_i,
    input  wire logic [3:0] split_mode_i,
    input  wire logic [3:0] alt_clk_tick_i,
    output logic            timer0_tick_o,
    output logic            timer1_tick_o,
    output logic      [3:0] lower_tick_o,
    output logic      [3:0] upper_tick_o,
    output logic            timer0_count_en_o,
    output logic            timer1_count_en_o,
    output logic            timer0_run_bit_o,
    output logic            timer1_run_bit_o,
    output logic            timer0_overflow_flag_o,
    output logic            timer1_overflow_flag_o,
    output logic            ext_irq0_flag_o,
    output logic            ext_irq1_flag_o,
    output logic            ext_irq0_type_sel_o,
    output logic            ext_irq1_type_sel_o
);
    import tcs_pkg::*;

    tcs_top_state_t q;
    tcs_top_state_t d;

    logic         wr_ctrl;
    logic         wr_cksel_a;
    logic         wr_cksel_b;
    logic         presc_tick;
    logic         ext_irq0_flag;
    logic         ext_irq1_flag;
    logic         ext_irq0_active;
    logic         ext_irq1_active;
    tcs_div_sel_t div_sel;
    logic         sel_lo;
    logic         sel_hi;

    // Index n is timer n+2; upper picks the split-mode upper byte select
    function automatic logic tcs_sel_bit(input logic [7:0] sel_a, input logic [3:0] sel_b,
                                         input int unsigned n, input logic upper);
        logic [7:0] packed_sel;
        packed_sel = {sel_b[`TCS_T5_UPPER_BIT], sel_b[`TCS_T5_LOWER_BIT],
                      sel_b[`TCS_T4_UPPER_BIT], sel_b[`TCS_T4_LOWER_BIT],
                      sel_a[`TCS_T3_UPPER_BIT], sel_a[`TCS_T3_LOWER_BIT],
                      sel_a[`TCS_T2_UPPER_BIT], sel_a[`TCS_T2_LOWER_BIT]};
        return packed_sel[3'(n * 2) + 3'(upper)];
    endfunction : tcs_sel_bit

    // Timer0/1 take the pin tick in counter mode, else pick between the system clock and the prescaler
    function automatic logic tcs_t01_tick(input logic counter_mode, input logic pin_tick,
                                          input logic sys_sel, input logic presc);
        logic t;
        if (counter_mode) begin
            t = pin_tick;
        end else if (sys_sel) begin
            t = 1'b1;
        end else begin
            t = presc;
        end
        return t;
    endfunction : tcs_t01_tick

    assign div_sel    = tcs_div_sel_t'(q.cksel_a[`TCS_DIV_SEL_HI:`TCS_DIV_SEL_LO]);
    assign wr_ctrl    = sfr_wr_i && (sfr_addr_i == `TCS_CTRL_ADDR);
    assign wr_cksel_a = sfr_wr_i && (sfr_addr_i == `TCS_CKSEL_A_ADDR);
    assign wr_cksel_b = sfr_wr_i && (sfr_addr_i == `TCS_CKSEL_B_ADDR);

    tcs_prescaler #(
        .COUNT_W (6)
    ) u_prescaler (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .clk_en_i  (clk_en_i),
        .div_sel_i (div_sel),
        .tick_o    (presc_tick)
    );

    tcs_ext_irq u_ext_irq0 (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .clk_en_i    (clk_en_i),
        .pin_i       (ext_irq0_input_i),
        .polarity_i  (ext_irq0_polarity_i),
        .edge_mode_i (q.ext_irq0_type_sel),
        .wr_en_i     (wr_ctrl),
        .wr_val_i    (sfr_wdata_i[`TCS_EIRQ0_FLAG_BIT]),
        .vector_i    (ext_irq0_vector_i),
        .flag_o      (ext_irq0_flag),
        .active_o    (ext_irq0_active)
    );

    tcs_ext_irq u_ext_irq1 (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .clk_en_i    (clk_en_i),
        .pin_i       (ext_irq1_input_i),
        .polarity_i  (ext_irq1_polarity_i),
        .edge_mode_i (q.ext_irq1_type_sel),
        .wr_en_i     (wr_ctrl),
        .wr_val_i    (sfr_wdata_i[`TCS_EIRQ1_FLAG_BIT]),
        .vector_i    (ext_irq1_vector_i),
        .flag_o      (ext_irq1_flag),
        .active_o    (ext_irq1_active)
    );

    always_comb begin
        d      = q;
        sel_lo = 1'b0;
        sel_hi = 1'b0;

        // Register writes
        if (wr_ctrl) begin
            d.timer1_overflow_flag = sfr_wdata_i[`TCS_T1_OVF_BIT];
            d.timer1_run_bit       = sfr_wdata_i[`TCS_T1_RUN_BIT];
            d.timer0_overflow_flag = sfr_wdata_i[`TCS_T0_OVF_BIT];
            d.timer0_run_bit       = sfr_wdata_i[`TCS_T0_RUN_BIT];
            d.ext_irq1_type_sel    = sfr_wdata_i[`TCS_EIRQ1_TYPE_BIT];
            d.ext_irq0_type_sel    = sfr_wdata_i[`TCS_EIRQ0_TYPE_BIT];
        end
        if (wr_cksel_a) begin
            d.cksel_a = sfr_wdata_i;
        end
        // Reserved upper bits are not stored and read back as zero
        if (wr_cksel_b) begin
            d.cksel_b = sfr_wdata_i[`TCS_CKSEL_B_WIDTH-1:0];
        end

        // Overflow flags: vector entry clears, a new overflow still wins
        if (timer0_vector_i) begin // R12
            d.timer0_overflow_flag = 1'b0;
        end
        if (timer0_overflow_i) begin // R12
            d.timer0_overflow_flag = 1'b1;
        end
        if (timer1_vector_i) begin // R12
            d.timer1_overflow_flag = 1'b0;
        end
        if (timer1_overflow_i) begin // R12
            d.timer1_overflow_flag = 1'b1;
        end

        // Timer0/1 clocking; in counter mode the pin edge replaces the select
        d.t0_tick = tcs_t01_tick(timer0_counter_mode_i, timer0_pin_tick_i, // R08
                                 q.cksel_a[`TCS_T0_SEL_BIT], presc_tick); // R07
        d.t1_tick = tcs_t01_tick(timer1_counter_mode_i, timer1_pin_tick_i, // R08
                                 q.cksel_a[`TCS_T1_SEL_BIT], presc_tick); // R06

        // Timers 2 to 5: lower select drives the whole timer unless split
        for (int unsigned n = 0; n < 4; n++) begin
            sel_lo = tcs_sel_bit(q.cksel_a, q.cksel_b, n, 1'b0); // R02 R03 R04 R05
            sel_hi = tcs_sel_bit(q.cksel_a, q.cksel_b, n, 1'b1); // R01 R03 R04 R05
            d.lower_tick[n] = sel_lo | alt_clk_tick_i[n];
            if (split_mode_i[n]) begin // R01
                d.upper_tick[n] = sel_hi | alt_clk_tick_i[n];
            end else begin
                d.upper_tick[n] = d.lower_tick[n];
            end
        end

        // Gate uses the registered active level, one cycle behind the pin
        d.t0_count_en = q.timer0_run_bit & (~timer0_gating_bit_i | ext_irq0_active); // R11
        d.t1_count_en = q.timer1_run_bit & (~timer1_gating_bit_i | ext_irq1_active);

        // Read data is captured on the read strobe and held until the next one
        if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                `TCS_CTRL_ADDR: begin
                    d.rdata = {q.timer1_overflow_flag, q.timer1_run_bit,
                               q.timer0_overflow_flag, q.timer0_run_bit,
                               ext_irq1_flag, q.ext_irq1_type_sel,
                               ext_irq0_flag, q.ext_irq0_type_sel};
                end
                `TCS_CKSEL_A_ADDR: begin
                    d.rdata = q.cksel_a;
                end
                `TCS_CKSEL_B_ADDR: begin
                    d.rdata = {4'h0, q.cksel_b};
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q         <= '0;
            q.cksel_a <= `TCS_CKSEL_A_RESET;
            q.cksel_b <= `TCS_CKSEL_B_RESET;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign sfr_rdata_o            = q.rdata;
    assign timer0_tick_o          = q.t0_tick;
    assign timer1_tick_o          = q.t1_tick;
    assign lower_tick_o           = q.lower_tick;
    assign upper_tick_o           = q.upper_tick;
    assign timer0_count_en_o      = q.t0_count_en;
    assign timer1_count_en_o      = q.t1_count_en;
    assign timer0_run_bit_o       = q.timer0_run_bit;
    assign timer1_run_bit_o       = q.timer1_run_bit;
    assign timer0_overflow_flag_o = q.timer0_overflow_flag;
    assign timer1_overflow_flag_o = q.timer1_overflow_flag;
    assign ext_irq0_flag_o        = ext_irq0_flag;
    assign ext_irq1_flag_o        = ext_irq1_flag;
    assign ext_irq0_type_sel_o    = q.ext_irq0_type_sel;
    assign ext_irq1_type_sel_o    = q.ext_irq1_type_sel;

endmodule : tcs_top

/* tcs_top_props.sv */
`timescale 1ns/100ps
`include "tcs_cfg.svh"

module tcs_top_props (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       clk_en_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       timer0_counter_mode_i,
    input  wire logic       timer0_pin_tick_i,
    input  wire logic       timer0_overflow_i,
    input  wire logic       ext_irq0_input_i,
    input  wire logic       ext_irq0_polarity_i,
    input  wire logic [3:0] split_mode_i,
    input  wire logic [3:0] alt_clk_tick_i,
    input  wire logic       timer0_tick_o,
    input  wire logic [3:0] lower_tick_o,
    input  wire logic [3:0] upper_tick_o,
    input  wire logic       timer0_overflow_flag_o,
    input  wire logic       ext_irq0_flag_o,
    input  wire logic       ext_irq0_type_sel_o
);
    logic [7:0] sel_a_q;
    logic [3:0] sel_b_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Shadow of the clock selects, so the tick checks need no internal probes
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_a_q <= 8'h00;
            sel_b_q <= 4'h0;
        end else if (clk_en_i && sfr_wr_i) begin
            if (sfr_addr_i == `TCS_CKSEL_A_ADDR) sel_a_q <= sfr_wdata_i;
            if (sfr_addr_i == `TCS_CKSEL_B_ADDR) sel_b_q <= sfr_wdata_i[3:0];
        end
    end

    property p_t0_sys;
        $past(clk_en_i && reset_n_i && sel_a_q[2] && !timer0_counter_mode_i) |-> timer0_tick_o;
    endproperty
    a_t0_sys: assert property (p_t0_sys) else $error("timer0 tick missing");
    property p_t0_cnt;
        $past(clk_en_i && timer0_counter_mode_i) |-> timer0_tick_o == $past(timer0_pin_tick_i);
    endproperty
    a_t0_cnt: assert property (p_t0_cnt) else $error("timer0 pin tick");
    property p_t2_lo;
        $past(clk_en_i && reset_n_i) |-> lower_tick_o[0] == $past(sel_a_q[4] | alt_clk_tick_i[0]);
    endproperty
    a_t2_lo: assert property (p_t2_lo) else $error("timer2 lower tick");
    property p_t2_hi;
        $past(clk_en_i && reset_n_i && split_mode_i[0]) |->
            upper_tick_o[0] == $past(sel_a_q[5] | alt_clk_tick_i[0]);
    endproperty
    a_t2_hi: assert property (p_t2_hi) else $error("timer2 upper tick");
    property p_t4_lo;
        $past(clk_en_i && reset_n_i) |-> lower_tick_o[2] == $past(sel_b_q[0] | alt_clk_tick_i[2]);
    endproperty
    a_t4_lo: assert property (p_t4_lo) else $error("timer4 lower tick");
    property p_t5_hi;
        $past(clk_en_i && reset_n_i && split_mode_i[3]) |->
            upper_tick_o[3] == $past(sel_b_q[3] | alt_clk_tick_i[3]);
    endproperty
    a_t5_hi: assert property (p_t5_hi) else $error("timer5 upper tick");
    property p_ovf;
        $past(clk_en_i && reset_n_i && timer0_overflow_i) |-> timer0_overflow_flag_o;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");
    property p_lvl;
        $past(clk_en_i && reset_n_i && !ext_irq0_type_sel_o && ext_irq0_input_i == ext_irq0_polarity_i) |->
            ext_irq0_flag_o;
    endproperty
    a_lvl: assert property (p_lvl) else $error("level flag not set");
endmodule : tcs_top_props

bind tcs_top tcs_top_props i_props (.*);

/* test_timer_clock_select_and_control.sv */
`timescale 1ns/100ps

module test_timer_clock_select_and_control;
    logic       ref_clk_i, reset_n_i, clk_en_i, sfr_wr_i, sfr_rd_i;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    logic       timer0_counter_mode_i, timer1_counter_mode_i, timer0_pin_tick_i, timer1_pin_tick_i;
    logic       timer0_gating_bit_i, timer1_gating_bit_i, ext_irq0_input_i, ext_irq1_input_i;
    logic       ext_irq0_polarity_i, ext_irq1_polarity_i, timer0_overflow_i, timer1_overflow_i;
    logic       timer0_vector_i, timer1_vector_i, ext_irq0_vector_i, ext_irq1_vector_i;
    logic [3:0] split_mode_i, alt_clk_tick_i, lower_tick_o, upper_tick_o;
    logic       timer0_tick_o, timer1_tick_o, timer0_count_en_o, timer1_count_en_o;
    logic       timer0_run_bit_o, timer1_run_bit_o, timer0_overflow_flag_o, timer1_overflow_flag_o;
    logic       ext_irq0_flag_o, ext_irq1_flag_o, ext_irq0_type_sel_o, ext_irq1_type_sel_o;
    int         mismatches;
    int         samples_checked;

    tcs_top i_dut (.*);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : settle

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk_i);
        sfr_addr_i  <= addr;
        sfr_wdata_i <= data;
        sfr_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        sfr_wr_i    <= 1'b0;
    endtask : wr

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge ref_clk_i);
        sfr_addr_i <= addr;
        sfr_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        sfr_rd_i   <= 1'b0;
        @(negedge ref_clk_i);
        check(sfr_rdata_o, exp);
    endtask : expect_reg

    // Bits: ext1 vec, ext0 vec, t1 vec, t0 vec, t1 ovf, t0 ovf
    task automatic pulse(input logic [5:0] m);
        @(posedge ref_clk_i);
        {ext_irq1_vector_i, ext_irq0_vector_i, timer1_vector_i, timer0_vector_i, timer1_overflow_i,
         timer0_overflow_i} <= m;
        @(posedge ref_clk_i);
        {ext_irq1_vector_i, ext_irq0_vector_i, timer1_vector_i, timer0_vector_i, timer1_overflow_i,
         timer0_overflow_i} <= 6'h00;
        @(negedge ref_clk_i);
    endtask : pulse

    task automatic count_ticks(output int n0, output int n1);
        n0 = 0;
        n1 = 0;
        repeat (96) begin
            @(negedge ref_clk_i);
            n0 += (timer0_tick_o === 1'b1);
            n1 += (timer1_tick_o === 1'b1);
        end
    endtask : count_ticks

    task automatic test_regs;
        expect_reg(8'h88, 8'h00);
        expect_reg(8'h8e, 8'h00);
        expect_reg(8'ha6, 8'h00);
        expect_reg(8'h89, 8'h00);
        wr(8'h8e, 8'ha5);
        expect_reg(8'h8e, 8'ha5);
        wr(8'ha6, 8'hff);
        expect_reg(8'ha6, 8'h0f);
        wr(8'h88, 8'h55);
        expect_reg(8'h88, 8'h55);
        check({timer1_run_bit_o, timer0_run_bit_o, ext_irq1_type_sel_o, ext_irq0_type_sel_o}, 8'h0f);
        // A write while the block is frozen must be dropped
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        wr(8'h8e, 8'h00);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b1;
        expect_reg(8'h8e, 8'ha5);
        wr(8'h88, 8'h00);
        wr(8'ha6, 8'h00);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_clk_sel;
        logic [7:0] s;
        @(posedge ref_clk_i);
        split_mode_i <= 4'hf;
        for (int k = 0; k < 8; k++) begin
            s = 8'h01 << k;
            wr(8'h8e, {s[3:0], 4'h0});
            wr(8'ha6, {4'h0, s[7:4]});
            settle(2);
            check(lower_tick_o, {s[6], s[4], s[2], s[0]});
            check(upper_tick_o, {s[7], s[5], s[3], s[1]});
        end
        // Unsplit: upper selects are ignored and the whole timer follows the lower select
        @(posedge ref_clk_i);
        split_mode_i   <= 4'h0;
        alt_clk_tick_i <= 4'ha;
        wr(8'h8e, 8'ha0);
        wr(8'ha6, 8'h0a);
        settle(2);
        check(upper_tick_o, 8'h0a);
        wr(8'h8e, 8'h50);
        wr(8'ha6, 8'h05);
        settle(2);
        check(lower_tick_o, 8'h0f);
        @(posedge ref_clk_i);
        alt_clk_tick_i <= 4'h0;
        $display("test_clk_sel done");
    endtask : test_clk_sel

    task automatic test_presc;
        int         n0;
        int         n1;
        // Reserved code 3 falls back to the divide-by-12 ratio
        logic [7:0] div [4] = '{8'd12, 8'd4, 8'd48, 8'd12};
        for (int c = 0; c < 4; c++) begin
            wr(8'h8e, 8'(c));
            settle(60);
            count_ticks(n0, n1);
            check(8'(n0), 8'(96 / div[c]));
            check(8'(n1), 8'(96 / div[c]));
        end
        wr(8'h8e, 8'h0c);
        settle(2);
        count_ticks(n0, n1);
        check(8'(n0 + n1), 8'd192);
        @(posedge ref_clk_i);
        {timer1_counter_mode_i, timer0_counter_mode_i} <= 2'b11;
        settle(2);
        count_ticks(n0, n1);
        check(8'(n0 + n1), 8'd0);
        @(posedge ref_clk_i);
        {timer1_pin_tick_i, timer0_pin_tick_i} <= 2'b11;
        @(posedge ref_clk_i);
        {timer1_pin_tick_i, timer0_pin_tick_i} <= 2'b00;
        @(negedge ref_clk_i);
        check({timer1_tick_o, timer0_tick_o}, 8'h03);
        @(posedge ref_clk_i);
        {timer1_counter_mode_i, timer0_counter_mode_i} <= 2'b00;
        wr(8'h8e, 8'h00);
        $display("test_presc done");
    endtask : test_presc

    task automatic test_flags;
        pulse(6'h03);
        check({timer1_overflow_flag_o, timer0_overflow_flag_o}, 8'h03);
        pulse(6'h0c);
        check({timer1_overflow_flag_o, timer0_overflow_flag_o}, 8'h00);
        pulse(6'h0f);
        check({timer1_overflow_flag_o, timer0_overflow_flag_o}, 8'h03);
        wr(8'h88, 8'h00);
        settle(1);
        check({timer1_overflow_flag_o, timer0_overflow_flag_o}, 8'h00);
        @(posedge ref_clk_i);
        {ext_irq1_input_i, ext_irq0_input_i} <= 2'b11;
        pulse(6'h30);
        check({ext_irq1_flag_o, ext_irq0_flag_o}, 8'h03);
        @(posedge ref_clk_i);
        {ext_irq1_input_i, ext_irq0_input_i} <= 2'b00;
        wr(8'h88, 8'h05);
        @(posedge ref_clk_i);
        {ext_irq1_input_i, ext_irq0_input_i} <= 2'b11;
        settle(2);
        check({ext_irq1_flag_o, ext_irq0_flag_o}, 8'h03);
        pulse(6'h30);
        check({ext_irq1_flag_o, ext_irq0_flag_o}, 8'h00);
        @(posedge ref_clk_i);
        {ext_irq1_polarity_i, ext_irq0_polarity_i} <= 2'b00;
        @(posedge ref_clk_i);
        {ext_irq1_input_i, ext_irq0_input_i} <= 2'b00;
        settle(2);
        check({ext_irq1_flag_o, ext_irq0_flag_o}, 8'h03);
        @(posedge ref_clk_i);
        {ext_irq1_polarity_i, ext_irq0_polarity_i} <= 2'b11;
        wr(8'h88, 8'h00);
        settle(1);
        check({ext_irq1_flag_o, ext_irq0_flag_o}, 8'h00);
        $display("test_flags done");
    endtask : test_flags

    task automatic test_count_en;
        @(posedge ref_clk_i);
        {timer1_gating_bit_i, timer0_gating_bit_i} <= 2'b11;
        wr(8'h88, 8'h50);
        settle(3);
        check({timer1_count_en_o, timer0_count_en_o}, 8'h00);
        @(posedge ref_clk_i);
        {ext_irq1_input_i, ext_irq0_input_i} <= 2'b11;
        settle(3);
        check({timer1_count_en_o, timer0_count_en_o}, 8'h03);
        @(posedge ref_clk_i);
        {timer1_gating_bit_i, timer0_gating_bit_i} <= 2'b00;
        {ext_irq1_input_i, ext_irq0_input_i}       <= 2'b00;
        settle(3);
        check({timer1_count_en_o, timer0_count_en_o}, 8'h03);
        wr(8'h88, 8'h00);
        settle(2);
        check({timer1_count_en_o, timer0_count_en_o}, 8'h00);
        $display("test_count_en done");
    endtask : test_count_en

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        mismatches      = 0;
        samples_checked = 0;
        {reset_n_i, sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i, split_mode_i, alt_clk_tick_i} = '0;
        {timer0_counter_mode_i, timer1_counter_mode_i, timer0_pin_tick_i, timer1_pin_tick_i} = '0;
        {timer0_gating_bit_i, timer1_gating_bit_i, ext_irq0_input_i, ext_irq1_input_i} = '0;
        {timer0_overflow_i, timer1_overflow_i, timer0_vector_i, timer1_vector_i} = '0;
        {ext_irq0_vector_i, ext_irq1_vector_i} = '0;
        // Active-high interrupt pins idle low, so nothing fires at release
        {clk_en_i, ext_irq0_polarity_i, ext_irq1_polarity_i} = 3'b111;
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        test_regs;
        test_clk_sel;
        test_presc;
        test_flags;
        test_count_en;
        summarize;
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        summarize;
    end
endmodule : test_timer_clock_select_and_control
